// ---- design/led_command_port_and_pwm.sv ----
// What this block does
// RULE_01 - Serial data is sampled into the shift register on each rising shift clock.
// RULE_02 - Words travel most significant bit first, bit 15 first and bit 0 last.
// RULE_03 - The shift register holds exactly sixteen bits, one shifted per clock.
// RULE_04 - Load strobe going low copies the shift register into the command word.
// RULE_05 - A newly latched command is applied to all outputs at once.
// RULE_06 - The serial port is static; any slow shift clock or pause works.
// RULE_07 - Bits 15 and 14 set the level of all four main outputs.
// RULE_08 - Bits 13 and 12 set the level of both sub outputs.
// RULE_09 - Level codes 00, 01, 10, 11 give 0, 25, 50, 100 percent.
// RULE_10 - Blue duty in bits 11 to 8, green 7 to 4, red 3 to 0.
// RULE_11 - Duty value n gives n fifteenths on-time; 0 off, 15 always on.
// RULE_12 - Colour modulation runs at the pump oscillator rate divided by 240.
// RULE_13 - A 240-step counter forms fifteen slots of sixteen; on for n slots.
// RULE_14 - Colour enable high shows the programmed colours; low disables them.
// RULE_15 - With main or sub enabled the pump starts in 1:1 direct mode.
// RULE_16 - Any main or sub dropout switches to 2:3 boost with soft-start.
// RULE_17 - Boost entry ramps available pump current linearly over 1.2 ms.
// RULE_18 - Any nonzero colour duty with colour enable high keeps the charge pump running continuously.
// RULE_19 - Colour outputs never take part in dropout or pump mode choice.
// RULE_20 - A white output within 1 V of pump output is off, no dropout.
// RULE_21 - An open or grounded white output counts as being in dropout.
// RULE_22 - The zero main and sub level is the shutdown level for them.
// RULE_23 - Main and sub both zero with colour enable low means shutdown.
// RULE_24 - A grounded logic reference supply holds the device in shutdown.
// RULE_25 - Force boost high keeps the pump in 2:3 mode over automatic switching.
`include "led_consts.svh"
`default_nettype none
module led_command_port_and_pwm #(
  parameter int SOFT_START_CYCLES = `SOFT_START_NS / `MCLK_PERIOD_NS
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic shiftClk,
  input wire logic serialData,
  input wire logic loadStrobeN,
  input wire logic colorEnable,
  input wire logic forceBoost,
  input wire logic logicReferenceSupply,
  input wire logic [5:0] whiteDropout,
  input wire logic [5:0] whiteNearPump,
  input wire logic [5:0] whiteOpenOrShort,
  output logic [3:0] mainLedOutputs,
  output logic [1:0] subLedOutputs,
  output logic [2:0] mainMultiplier,
  output logic [2:0] subMultiplier,
  output logic [2:0] colorOutputs,
  output logic pumpRun,
  output logic pumpDirect,
  output logic pumpBoost,
  output logic [7:0] pumpStrength,
  output logic shutdown,
  output logic [15:0] ledCommandWord
);

  localparam int RAMP_STEP_RAW = SOFT_START_CYCLES / `RAMP_STEPS;
  localparam int RAMP_STEP_CYCLES = (RAMP_STEP_RAW < 1) ? 1 : RAMP_STEP_RAW;
  localparam int STEP_W = $clog2(RAMP_STEP_CYCLES + 1);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(RAMP_STEP_CYCLES - 1);
  localparam logic [STEP_W-1:0] STEP_ZERO = '0;

  // ****************************************************************
  // Shift clock domain.
  // ****************************************************************
  // No reset and no bit counter here: the register only ever holds the
  // last sixteen bits seen, so it needs no edge outside a transfer.
  logic [`CMD_WIDTH-1:0] shiftReg_q;

  always_ff @(posedge shiftClk) begin
    shiftReg_q <= {shiftReg_q[`CMD_WIDTH-2:0], serialData}; // RULE_01 RULE_02 RULE_03 RULE_06
  end

  // ****************************************************************
  // Crossing into the system clock domain.
  // ****************************************************************
  // The word is stable while the host holds the shift clock after the
  // load strobe falls, so it is sampled through two stages and taken
  // only when the synchronised falling strobe qualifies it.
  logic loadSync1_q, loadSync2_q, loadSync3_q;
  logic [`CMD_WIDTH-1:0] wordSync1_q, wordSync2_q;
  logic [2:0] inSync1_q, inSync2_q;
  logic [5:0] dropSync1_q, dropSync2_q;
  logic [5:0] nearSync1_q, nearSync2_q;
  logic [5:0] faultSync1_q, faultSync2_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      loadSync1_q <= 1'b1;
      loadSync2_q <= 1'b1;
      loadSync3_q <= 1'b1;
      wordSync1_q <= `CMD_RESET;
      wordSync2_q <= `CMD_RESET;
    end else begin
      loadSync1_q <= loadStrobeN;
      loadSync2_q <= loadSync1_q;
      loadSync3_q <= loadSync2_q;
      wordSync1_q <= shiftReg_q;
      wordSync2_q <= wordSync1_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      inSync1_q <= 3'h0;
      inSync2_q <= 3'h0;
      dropSync1_q <= 6'h00;
      dropSync2_q <= 6'h00;
      nearSync1_q <= 6'h00;
      nearSync2_q <= 6'h00;
      faultSync1_q <= 6'h00;
      faultSync2_q <= 6'h00;
    end else begin
      inSync1_q <= {logicReferenceSupply, forceBoost, colorEnable};
      inSync2_q <= inSync1_q;
      dropSync1_q <= whiteDropout;
      dropSync2_q <= dropSync1_q;
      nearSync1_q <= whiteNearPump;
      nearSync2_q <= nearSync1_q;
      faultSync1_q <= whiteOpenOrShort;
      faultSync2_q <= faultSync1_q;
    end
  end

  wire colorEn = inSync2_q[0];
  wire forceEn = inSync2_q[1];
  wire supplyUp = inSync2_q[2];
  wire loadFall = loadSync3_q & ~loadSync2_q;

  // ****************************************************************
  // Command register.
  // ****************************************************************
  logic [`CMD_WIDTH-1:0] cmd_q;
  wire [`CMD_WIDTH-1:0] cmd_d = loadFall ? wordSync2_q : cmd_q; // RULE_04

  always_ff @(posedge mclk) begin
    if (reset) begin
      cmd_q <= `CMD_RESET;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  // ****************************************************************
  // Field decode.
  // ****************************************************************
  wire led_pkg::level_t mainLevel = cmd_q[`MAIN_HI:`MAIN_LO]; // RULE_07
  wire led_pkg::level_t subLevel = cmd_q[`SUB_HI:`SUB_LO]; // RULE_08
  wire led_pkg::duty_t blueDuty = cmd_q[`BLUE_HI:`BLUE_LO]; // RULE_10
  wire led_pkg::duty_t greenDuty = cmd_q[`GREEN_HI:`GREEN_LO];
  wire led_pkg::duty_t redDuty = cmd_q[`RED_HI:`RED_LO];

  function automatic logic [2:0] levelMult(input led_pkg::level_t lvl);
    logic [2:0] m;
    m = `MULT_OFF;
    if (lvl == `LEVEL_25) begin
      m = `MULT_25;
    end else if (lvl == `LEVEL_50) begin
      m = `MULT_50;
    end else if (lvl == `LEVEL_100) begin
      m = `MULT_100;
    end
    return m; // RULE_09
  endfunction

  wire mainActive = mainLevel != `LEVEL_OFF; // RULE_22
  wire subActive = subLevel != `LEVEL_OFF;
  wire whiteActive = mainActive | subActive;
  wire colorProgrammed = (redDuty != `DUTY_OFF) | (greenDuty != `DUTY_OFF) | (blueDuty != `DUTY_OFF);
  wire shutdownNow = ~supplyUp | (~whiteActive & ~colorEn); // RULE_23 RULE_24

  // ****************************************************************
  // White channel qualification.
  // ****************************************************************
  // A channel that is parked at the pump output is dropped before the
  // dropout test, so an unused pin can never pull the pump into boost.
  // Channels 0 to 3 are main, 4 and 5 are sub. Colour channels feed
  // nothing here, so they can never move the pump mode.
  logic [5:0] whiteEnabled;
  logic [5:0] whiteInDropout;

  genvar w;
  generate
    for (w = 0; w < 6; w++) begin : gWhite
      wire chanLevelOn = (w < 4) ? mainActive : subActive;
      assign whiteEnabled[w] = chanLevelOn & ~nearSync2_q[w] & ~shutdownNow; // RULE_20
      assign whiteInDropout[w] = whiteEnabled[w] & (dropSync2_q[w] | faultSync2_q[w]); // RULE_21 RULE_19
    end
  endgenerate

  wire anyDropout = |whiteInDropout;

  // ****************************************************************
  // Pump oscillator and colour modulation.
  // ****************************************************************
  // The oscillator is modelled as a fixed divider of the system clock,
  // so its rate does not wander with the supply as a real one would.
  // One modulation period is 240 oscillator ticks, or 30000 system
  // clocks; a new duty value takes effect one clock after it is latched, mid-slot.
  logic [6:0] oscCnt_q;
  logic [7:0] pwmCnt_q;
  wire oscTick = oscCnt_q == `OSC_CNT_MAX;
  wire [6:0] oscCnt_d = oscTick ? 7'h00 : oscCnt_q + 7'h01;
  wire pwmWrap = pwmCnt_q == `PWM_CNT_MAX;
  wire [7:0] pwmStep = pwmWrap ? 8'h00 : pwmCnt_q + 8'h01;
  wire [7:0] pwmCnt_d = oscTick ? pwmStep : pwmCnt_q; // RULE_12
  wire [3:0] pwmSlot = pwmCnt_q[`PWM_SLOT_HI:`PWM_SLOT_LO]; // RULE_13

  always_ff @(posedge mclk) begin
    if (reset) begin
      oscCnt_q <= 7'h00;
      pwmCnt_q <= 8'h00;
    end else begin
      oscCnt_q <= oscCnt_d;
      pwmCnt_q <= pwmCnt_d;
    end
  end

  wire led_pkg::duty_t colorDuty [3] = '{blueDuty, greenDuty, redDuty};
  logic [2:0] colorOn_d;

  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : gColor
      // Slot runs 0 to 14, so duty 15 is always on and duty 0 never.
      assign colorOn_d[c] = colorEn & ~shutdownNow & (pwmSlot < colorDuty[2-c]); // RULE_11 RULE_14
    end
  endgenerate

  // ****************************************************************
  // Pump mode control.
  // ****************************************************************
  // Once in boost the pump stays there until shutdown; going back to
  // direct mode on a rising battery would need hysteresis we lack.
  // The step counter is cleared outside soft-start and the ramp is
  // cleared outside boost, so every entry into boost ramps from zero.
  led_pkg::pumpMode_e mode_q, mode_d;
  logic [STEP_W-1:0] stepCnt_q;
  logic [7:0] ramp_q;
  wire rampStep = stepCnt_q == STEP_LAST;
  wire rampDone = ramp_q == `RAMP_MAX;
  wire [STEP_W-1:0] stepCnt_d = (mode_q == led_pkg::PUMP_SOFTSTART && !rampStep) ? stepCnt_q + STEP_W'(1) : STEP_ZERO;

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      led_pkg::PUMP_OFF: begin
        if (!shutdownNow) begin
          mode_d = led_pkg::PUMP_DIRECT; // RULE_15
        end
      end
      led_pkg::PUMP_DIRECT: begin
        if (shutdownNow) begin
          mode_d = led_pkg::PUMP_OFF;
        end else if (anyDropout || forceEn) begin
          mode_d = led_pkg::PUMP_SOFTSTART; // RULE_16 RULE_25
        end
      end
      led_pkg::PUMP_SOFTSTART: begin
        if (shutdownNow) begin
          mode_d = led_pkg::PUMP_OFF;
        end else if (rampDone) begin
          mode_d = led_pkg::PUMP_BOOST;
        end
      end
      default: begin
        if (shutdownNow) begin
          mode_d = led_pkg::PUMP_OFF;
        end
      end
    endcase
  end

  logic [7:0] ramp_d;
  always_comb begin
    ramp_d = ramp_q;
    if (mode_q == led_pkg::PUMP_SOFTSTART) begin
      if (rampStep && !rampDone) begin
        ramp_d = ramp_q + 8'h01; // RULE_17
      end
    end else if (mode_q == led_pkg::PUMP_BOOST) begin
      ramp_d = `RAMP_MAX;
    end else begin
      ramp_d = `RAMP_ZERO;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mode_q <= led_pkg::PUMP_OFF;
      stepCnt_q <= STEP_ZERO;
      ramp_q <= `RAMP_ZERO;
    end else begin
      mode_q <= mode_d;
      stepCnt_q <= stepCnt_d;
      ramp_q <= ramp_d;
    end
  end

  // ****************************************************************
  // Registered outputs.
  // ****************************************************************
  // Every output comes from a flip-flop, so the pins never glitch while
  // the decode above settles after a new command word.
  // The cost is one clock of extra latency on every output.
  wire inBoost = mode_q == led_pkg::PUMP_SOFTSTART || mode_q == led_pkg::PUMP_BOOST;
  wire pumpRun_d = ~shutdownNow & (whiteActive | (colorEn & colorProgrammed)); // RULE_18

  always_ff @(posedge mclk) begin
    if (reset) begin
      mainLedOutputs <= 4'h0;
      subLedOutputs <= 2'h0;
      mainMultiplier <= `MULT_OFF;
      subMultiplier <= `MULT_OFF;
      colorOutputs <= 3'h0;
    end else begin
      mainLedOutputs <= whiteEnabled[3:0]; // RULE_05
      subLedOutputs <= whiteEnabled[5:4];
      mainMultiplier <= shutdownNow ? `MULT_OFF : levelMult(mainLevel);
      subMultiplier <= shutdownNow ? `MULT_OFF : levelMult(subLevel);
      colorOutputs <= colorOn_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pumpRun <= 1'b0;
      pumpDirect <= 1'b0;
      pumpBoost <= 1'b0;
      pumpStrength <= `RAMP_ZERO;
      shutdown <= 1'b1;
      ledCommandWord <= `CMD_RESET;
    end else begin
      pumpRun <= pumpRun_d;
      pumpDirect <= pumpRun_d & (mode_q == led_pkg::PUMP_DIRECT);
      pumpBoost <= pumpRun_d & inBoost;
      pumpStrength <= ramp_q;
      shutdown <= shutdownNow;
      ledCommandWord <= cmd_q;
    end
  end

endmodule
`default_nettype wire

// ---- design/led_consts.svh ----
`ifndef LED_CONSTS_SVH
`define LED_CONSTS_SVH

// ****************************************************************
// Command word layout.
// ****************************************************************
`define CMD_WIDTH 16
`define CMD_RESET 16'h0000
`define MAIN_HI 15
`define MAIN_LO 14
`define SUB_HI 13
`define SUB_LO 12
`define BLUE_HI 11
`define BLUE_LO 8
`define GREEN_HI 7
`define GREEN_LO 4
`define RED_HI 3
`define RED_LO 0

// ****************************************************************
// Level codes and current multipliers in units of 25 percent.
// ****************************************************************
`define LEVEL_OFF 2'h0
`define LEVEL_25 2'h1
`define LEVEL_50 2'h2
`define LEVEL_100 2'h3
`define MULT_OFF 3'h0
`define MULT_25 3'h1
`define MULT_50 3'h2
`define MULT_100 3'h4
`define DUTY_OFF 4'h0

// ****************************************************************
// Timing.
// ****************************************************************
`define MCLK_PERIOD_NS 10
`define OSC_PERIOD_NS 1250
`define OSC_CYCLES (`OSC_PERIOD_NS / `MCLK_PERIOD_NS)
`define OSC_CNT_MAX 7'h7C
`define PWM_CNT_MAX 8'hEF
`define PWM_SLOT_HI 7
`define PWM_SLOT_LO 4
`define SOFT_START_NS 1200000
`define RAMP_ZERO 8'h00
`define RAMP_MAX 8'hFF
`define RAMP_STEPS 255

`endif

// ---- design/led_pkg.sv ----
`default_nettype none
package led_pkg;

  typedef enum logic [1:0] {
    PUMP_OFF,
    PUMP_DIRECT,
    PUMP_SOFTSTART,
    PUMP_BOOST
  } pumpMode_e;

  typedef logic [1:0] level_t;
  typedef logic [3:0] duty_t;

endpackage
`default_nettype wire

// ---- tb/led_command_port_and_pwm_assertions.sv ----
`default_nettype none
module led_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic colorEnable,
  input wire logic forceBoost,
  input wire logic logicReferenceSupply,
  input wire logic [2:0] mainMultiplier,
  input wire logic [2:0] subMultiplier,
  input wire logic [2:0] colorOutputs,
  input wire logic pumpBoost,
  input wire logic [7:0] pumpStrength,
  input wire logic shutdown,
  input wire logic [15:0] ledCommandWord
);
  // *****
  // Output relations, judged after the two-flop input syncs settle.
  // *****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_suppOff; (!logicReferenceSupply) [*5] |-> shutdown; endproperty
  a_suppOff: assert property (p_suppOff) else $error("no shutdown, supply low");
  property p_idle; (ledCommandWord[15:12] == 4'h0 && !colorEnable) [*5] |-> shutdown; endproperty
  a_idle: assert property (p_idle) else $error("no shutdown when idle");
  property p_colOff; (!colorEnable) [*5] |-> colorOutputs == 3'h0; endproperty
  a_colOff: assert property (p_colOff) else $error("colour on while disabled");
  property p_redZero; (ledCommandWord[3:0] == 4'h0) [*3] |-> !colorOutputs[0]; endproperty
  a_redZero: assert property (p_redZero) else $error("red on at zero duty");
  property p_mainMult; (!shutdown && $stable(ledCommandWord)) [*3] |-> mainMultiplier ==
    {&ledCommandWord[15:14], ledCommandWord[15:14] == 2'h2, ledCommandWord[15:14] == 2'h1}; endproperty
  a_mainMult: assert property (p_mainMult) else $error("main level wrong");
  property p_subMult; (!shutdown && $stable(ledCommandWord)) [*3] |-> subMultiplier ==
    {&ledCommandWord[13:12], ledCommandWord[13:12] == 2'h2, ledCommandWord[13:12] == 2'h1}; endproperty
  a_subMult: assert property (p_subMult) else $error("sub level wrong");
  property p_ramp; pumpBoost && $past(pumpBoost) |-> pumpStrength >= $past(pumpStrength); endproperty
  a_ramp: assert property (p_ramp) else $error("pump strength fell in boost");
  property p_boostHold; $fell(pumpBoost) |-> shutdown; endproperty
  a_boostHold: assert property (p_boostHold) else $error("boost left without shutdown");
  property p_force; (forceBoost && !shutdown) [*8] |-> pumpBoost; endproperty
  a_force: assert property (p_force) else $error("forced boost missing");
endmodule
`default_nettype wire

// ---- tb/serial_host_model.sv ----
`default_nettype none
module serial_host_model (
  output logic shiftClk,
  output logic serialData,
  output logic loadStrobeN
);
  timeunit 1ns;
  timeprecision 100ps;
  // *****
  // Write-only host; its clock rests high between frames.
  // *****
  initial begin
    shiftClk = 1'b1;
    serialData = 1'b0;
    loadStrobeN = 1'b1;
  end
  task automatic send(input logic [15:0] word, input int gap);
    for (int k = 15; k >= 0; k--) begin
      #7.5;
      shiftClk = 1'b0;
      serialData = word[k];
      #7.5;
      shiftClk = 1'b1;
      #gap;
    end
    // The clock stays still past the strobe, and the data until it rises, so the slow side never sees a torn word.
    #40;
    loadStrobeN = 1'b0;
    #60;
    loadStrobeN = 1'b1;
    serialData = ~word[0];
    #60;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_led_command_port_and_pwm.sv ----
`default_nettype none
`define CHK(a, b) begin \
  numChecks++; \
  if ((a) !== (b)) begin \
    numErrors++; \
    $display("[FAIL] %0t %h %h", $time, a, b); \
  end \
end
module test_led_command_port_and_pwm;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic colorEnable = 1'b0;
  logic forceBoost = 1'b0;
  logic logicReferenceSupply = 1'b1;
  logic [5:0] whiteDropout = 6'h00;
  logic [5:0] whiteNearPump = 6'h00;
  logic [5:0] whiteOpenOrShort = 6'h00;
  wire logic shiftClk, serialData, loadStrobeN;
  logic [3:0] mainLedOutputs;
  logic [1:0] subLedOutputs;
  logic [2:0] mainMultiplier, subMultiplier, colorOutputs;
  logic pumpRun, pumpDirect, pumpBoost, shutdown;
  logic [7:0] pumpStrength;
  logic [15:0] ledCommandWord;
  int numErrors = 0;
  int numChecks = 0;
  int cyc = 0;
  int n;
  serial_host_model host(.shiftClk(shiftClk), .serialData(serialData), .loadStrobeN(loadStrobeN));
  led_command_port_and_pwm #(.SOFT_START_CYCLES(1020)) uut(.mclk(mclk), .reset(reset), .shiftClk(shiftClk),
    .serialData(serialData), .loadStrobeN(loadStrobeN), .colorEnable(colorEnable), .forceBoost(forceBoost),
    .logicReferenceSupply(logicReferenceSupply), .whiteDropout(whiteDropout), .whiteNearPump(whiteNearPump),
    .whiteOpenOrShort(whiteOpenOrShort), .mainLedOutputs(mainLedOutputs), .subLedOutputs(subLedOutputs),
    .mainMultiplier(mainMultiplier), .subMultiplier(subMultiplier), .colorOutputs(colorOutputs),
    .pumpRun(pumpRun), .pumpDirect(pumpDirect), .pumpBoost(pumpBoost), .pumpStrength(pumpStrength),
    .shutdown(shutdown), .ledCommandWord(ledCommandWord));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // Waits past the edge so that outputs launched on it have settled before they are read.
  task automatic wt(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic load(input logic [15:0] w, input int gap);
    host.send(w, gap);
    wt(4);
    `CHK(ledCommandWord, w)
  endtask
  task automatic tLevels;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      load({c, c, 12'h000}, i * 50);
      `CHK(mainMultiplier, {c == 2'h3, c == 2'h2, c == 2'h1})
      `CHK(subMultiplier, {c == 2'h3, c == 2'h2, c == 2'h1})
      `CHK({mainLedOutputs, subLedOutputs}, {6{c != 2'h0}})
      `CHK(shutdown, c == 2'h0)
    end
  endtask
  task automatic tColor;
    int on[3];
    @(posedge mclk);
    colorEnable <= 1'b1;
    load(16'h0F05, 0);
    wt(10);
    on = '{0, 0, 0};
    repeat (30000) begin
      wt(1);
      for (int k = 0; k < 3; k++) on[k] += colorOutputs[k];
    end
    `CHK(on[0], 10000)
    `CHK(on[1], 0)
    `CHK(on[2], 30000)
    `CHK({pumpRun, pumpBoost, shutdown}, 3'h4)
    @(posedge mclk);
    colorEnable <= 1'b0;
    wt(8);
    `CHK({colorOutputs, shutdown}, 4'h1)
    @(posedge mclk);
    colorEnable <= 1'b1;
    wt(8);
    `CHK(colorOutputs[2], 1'b1)
  endtask
  task automatic tPump;
    @(posedge mclk);
    colorEnable <= 1'b0;
    whiteNearPump <= 6'h01;
    whiteDropout <= 6'h01;
    load(16'h4000, 0);
    wt(8);
    `CHK({pumpDirect, pumpBoost, pumpStrength, mainLedOutputs}, {2'h2, 8'h00, 4'hE})
    @(posedge mclk);
    whiteOpenOrShort <= 6'h02;
    n = 0;
    while (pumpBoost !== 1'b1 && n < 20) begin
      wt(1);
      n++;
    end
    `CHK({pumpBoost, pumpStrength <= 8'h01}, 2'h3)
    n = 0;
    while (pumpStrength !== 8'hFF && n < 2000) begin
      wt(1);
      n++;
    end
    `CHK(n >= 1010 && n <= 1025, 1'b1)
    @(posedge mclk);
    logicReferenceSupply <= 1'b0;
    whiteOpenOrShort <= 6'h00;
    wt(8);
    `CHK({shutdown, pumpBoost, pumpRun}, 3'h4)
    @(posedge mclk);
    logicReferenceSupply <= 1'b1;
    forceBoost <= 1'b1;
    wt(12);
    `CHK({shutdown, pumpBoost}, 2'h1)
  endtask
  task automatic finalReport;
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      numErrors++;
      finalReport;
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    wt(4);
    `CHK({ledCommandWord, shutdown}, 17'h00001)
    tLevels;
    tColor;
    tPump;
    finalReport;
  end
endmodule
bind led_command_port_and_pwm led_checker chk(.mclk(mclk), .reset(reset), .colorEnable(colorEnable),
  .forceBoost(forceBoost), .logicReferenceSupply(logicReferenceSupply), .mainMultiplier(mainMultiplier),
  .subMultiplier(subMultiplier), .colorOutputs(colorOutputs), .pumpBoost(pumpBoost),
  .pumpStrength(pumpStrength), .shutdown(shutdown), .ledCommandWord(ledCommandWord));
`default_nettype wire
